// ### lddr_pkg.sv
// Constants for the legacy device range decoder
package lddr_pkg;

	// Register offsets, byte addresses in configuration space
	localparam logic [7:0] LDDR_OFF_FWD_ENABLES = 8'h5C;
	localparam logic [7:0] LDDR_OFF_SLOT9_WINDOW = 8'h60;
	localparam logic [7:0] LDDR_OFF_SERIAL_SLOT10 = 8'h64;
	localparam logic [7:0] LDDR_OFF_SLOT12_IO = 8'h68;
	localparam logic [7:0] LDDR_OFF_SLOT12_MEM = 8'h6C;
	localparam logic [7:0] LDDR_OFF_SLOT13_IO = 8'h70;
	localparam logic [7:0] LDDR_OFF_SLOT13_MEM = 8'h74;
	localparam int LDDR_NUM_REGS = 7;

	// Writable bits per register, index order; reserved bits read zero
	localparam logic [31:0] LDDR_WMASK_FWD_ENABLES = 32'h6000_0000;
	localparam logic [31:0] LDDR_WMASK_SLOT9_WINDOW = 32'h00EF_FFFF;
	localparam logic [31:0] LDDR_WMASK_SERIAL_SLOT10 = 32'hFFEF_FFFF;
	localparam logic [31:0] LDDR_WMASK_IO_WINDOW = 32'h001F_FFFF;
	localparam logic [31:0] LDDR_WMASK_MEM_WINDOW = 32'hFFFF_80FF;
	localparam logic [31:0] LDDR_REG_RESET = 32'h0000_0000;

	// Field positions
	localparam int LDDR_BIT_SLOT13_FWD = 30;
	localparam int LDDR_BIT_SLOT12_FWD = 29;
	localparam int LDDR_BIT_SERB_FWD = 31;
	localparam int LDDR_POS_SERB_SEL = 28;
	localparam int LDDR_BIT_SERA_FWD = 27;
	localparam int LDDR_POS_SERA_SEL = 24;
	localparam int LDDR_BIT_CS_EN = 23;
	localparam int LDDR_BIT_GEN_FWD = 22;
	localparam int LDDR_BIT_GEN_MON = 21;
	localparam int LDDR_BIT_IO_MON = 20;
	localparam int LDDR_POS_IO_MASK = 16;
	localparam int LDDR_POS_IO_BASE = 0;
	localparam int LDDR_POS_MEM_BASE = 15;
	localparam int LDDR_BIT_MEM_MON = 7;
	localparam int LDDR_POS_MEM_MASK = 0;

	// Window widths
	localparam int LDDR_IO_BASE_W = 16;
	localparam int LDDR_IO_MASK_W = 4;
	localparam int LDDR_MEM_BASE_W = 17;
	localparam int LDDR_MEM_MASK_W = 7;
	localparam int LDDR_SEL_W = 3;

	// Serial port range starts, address bits 15:3, one per select code
	localparam logic [12:0] LDDR_SER_RANGE_0 = 13'h007F;
	localparam logic [12:0] LDDR_SER_RANGE_1 = 13'h005F;
	localparam logic [12:0] LDDR_SER_RANGE_2 = 13'h0044;
	localparam logic [12:0] LDDR_SER_RANGE_3 = 13'h0045;
	localparam logic [12:0] LDDR_SER_RANGE_4 = 13'h0047;
	localparam logic [12:0] LDDR_SER_RANGE_5 = 13'h005D;
	localparam logic [12:0] LDDR_SER_RANGE_6 = 13'h0067;
	localparam logic [12:0] LDDR_SER_RANGE_7 = 13'h007D;

	// Hit vector positions
	localparam int LDDR_HIT_SLOT9 = 0;
	localparam int LDDR_HIT_SERA = 1;
	localparam int LDDR_HIT_SERB = 2;
	localparam int LDDR_HIT_SLOT10 = 3;
	localparam int LDDR_HIT_SLOT12_IO = 4;
	localparam int LDDR_HIT_SLOT12_MEM = 5;
	localparam int LDDR_HIT_SLOT13_IO = 6;
	localparam int LDDR_HIT_SLOT13_MEM = 7;
	localparam int LDDR_NUM_HITS = 8;

endpackage

// ### lddr_window_match.sv
// Base and mask window comparator
`timescale 1ns/1ps

module lddr_window_match #(
	parameter int BASE_W = 16,
	parameter int MASK_W = 4
) (
	// Address slice and window setup
	input wire logic [BASE_W-1:0] addr,
	input wire logic [BASE_W-1:0] base,
	input wire logic [MASK_W-1:0] mask,
	input wire logic enable,
	// Result
	output logic hit
);

	// Refused at elaboration: a mask must sit inside the base it qualifies
	if (MASK_W < 1 || MASK_W > BASE_W) begin : g_bad_width
		$error("lddr_window_match: mask must be 1 to BASE_W bits wide");
	end

	logic [BASE_W-1:0] care;

	// Mask one means ignore; split masks simply give split ranges
	assign care = ~{{(BASE_W-MASK_W){1'b0}}, mask};
	assign hit = enable && (((addr ^ base) & care) == '0); // [RULE23]

endmodule

// ### lddr_decoder.sv
// Legacy device range decoder: registers, window decode, claim and chip selects
`timescale 1ns/1ps

// Functional notes
// RULE1 - Slot 9 mask bits 19:16 cover address bits 3:0; one ignores the bit.
// RULE2 - Slot 9 16-bit base compares against address bits 15:0.
// RULE3 - Serial B forward plus monitor enable claims and forwards its range.
// RULE4 - Serial B select codes map to eight fixed eight-byte port ranges.
// RULE5 - Serial A forward plus monitor enable claims and forwards its range.
// RULE6 - Serial A select uses the same eight-entry range table.
// RULE7 - Slot 10 chip select plus forward asserts select 1 on window hits.
// RULE8 - Slot 10 forward claims and forwards hits in its enabled window.
// RULE9 - Slot 10 monitor enable turns on its window decode.
// RULE10 - Slot 10 16-bit base, 4-bit mask on bits 3:0; bit 20 reserved.
// RULE11 - Slot 12 I/O monitor enable turns on its I/O window decode.
// RULE12 - Slot 12 I/O window: 16-bit base, 4-bit mask over bits 3:0.
// RULE13 - Slot 12 memory base of 17 bits compares address bits 31:15.
// RULE14 - Slot 12 memory 7-bit mask covers address bits 21:15.
// RULE15 - Slot 12 memory monitor enable turns on its memory decode.
// RULE16 - Slot 13 I/O monitor enable turns on its I/O window decode.
// RULE17 - Slot 13 I/O window: 16-bit base, 4-bit mask over bits 3:0.
// RULE18 - Slot 13 memory: 17-bit base on 31:15, 7-bit mask on 21:15.
// RULE19 - Slot 13 memory monitor enable turns on its memory decode.
// RULE20 - Slot 9 monitor enable turns on its I/O window decode.
// RULE21 - Slot 9 chip select plus forward asserts select 0 on window hits.
// RULE22 - Slot 12 and 13 forward bits claim hits in their enabled windows.
// RULE23 - A hit needs all unmasked bits equal to base and monitor enabled.
// RULE24 - Every decode field clears to zero on reset.
module lddr_decoder
	import lddr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Configuration register port
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// Serial monitor enables held outside this block
	input wire logic serial_a_monitor_enable,
	input wire logic serial_b_monitor_enable,
	// Observed bus cycle
	input wire logic cyc_valid,
	input wire logic cyc_is_io,
	input wire logic [31:0] cyc_addr,
	// Decode results
	output logic claim,
	output logic peripheral_select_0_n,
	output logic peripheral_select_1_n,
	output logic [LDDR_NUM_HITS-1:0] window_hit
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [LDDR_NUM_REGS-1:0][31:0] regs;
		logic [31:0] rdata;
		logic rvalid;
		logic claim;
		logic sel0_n;
		logic sel1_n;
		logic [LDDR_NUM_HITS-1:0] hit;
	} lddr_state_t;

	lddr_state_t state_ff;
	lddr_state_t nxt_state;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// Index 4'hF marks an unmapped offset, so the table tops out at fifteen
	if (LDDR_NUM_REGS < 7 || LDDR_NUM_REGS > 15) begin : g_chk_regs
		$error("lddr_decoder: register table needs seven to fifteen entries");
	end

	if (LDDR_NUM_HITS != 8) begin : g_chk_hits
		$error("lddr_decoder: hit vector carries exactly eight windows");
	end

	if (LDDR_POS_IO_BASE + LDDR_IO_BASE_W > LDDR_POS_IO_MASK) begin : g_chk_io_base
		$error("lddr_decoder: I/O base overlaps the I/O mask");
	end

	if (LDDR_POS_IO_MASK + LDDR_IO_MASK_W > LDDR_BIT_IO_MON) begin : g_chk_io_mask
		$error("lddr_decoder: I/O mask overlaps the monitor enable");
	end

	// I/O windows always compare address bits 15:0
	if (LDDR_IO_BASE_W != 16 || LDDR_IO_MASK_W > LDDR_IO_BASE_W) begin : g_chk_io_w
		$error("lddr_decoder: I/O window widths do not fit address bits 15:0");
	end

	// Memory windows always compare address bits 31:15
	if (LDDR_MEM_BASE_W != 17 || LDDR_POS_MEM_BASE + LDDR_MEM_BASE_W != 32) begin : g_chk_mem_base
		$error("lddr_decoder: memory base must cover address bits 31:15");
	end

	if (LDDR_POS_MEM_MASK + LDDR_MEM_MASK_W > LDDR_BIT_MEM_MON) begin : g_chk_mem_mask
		$error("lddr_decoder: memory mask overlaps the monitor enable");
	end

	if (LDDR_MEM_MASK_W > LDDR_MEM_BASE_W) begin : g_chk_mem_w
		$error("lddr_decoder: memory mask wider than memory base");
	end

	if (LDDR_SEL_W != 3 || LDDR_POS_SERB_SEL + LDDR_SEL_W > LDDR_BIT_SERB_FWD) begin : g_chk_serb
		$error("lddr_decoder: serial B select does not fit below its forward bit");
	end

	if (LDDR_POS_SERA_SEL + LDDR_SEL_W > LDDR_BIT_SERA_FWD) begin : g_chk_sera
		$error("lddr_decoder: serial A select does not fit below its forward bit");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode, shared by read and write

	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a == LDDR_OFF_FWD_ENABLES) begin
			reg_index = 4'h0;
		end else if (a == LDDR_OFF_SLOT9_WINDOW) begin
			reg_index = 4'h1;
		end else if (a == LDDR_OFF_SERIAL_SLOT10) begin
			reg_index = 4'h2;
		end else if (a == LDDR_OFF_SLOT12_IO) begin
			reg_index = 4'h3;
		end else if (a == LDDR_OFF_SLOT12_MEM) begin
			reg_index = 4'h4;
		end else if (a == LDDR_OFF_SLOT13_IO) begin
			reg_index = 4'h5;
		end else if (a == LDDR_OFF_SLOT13_MEM) begin
			reg_index = 4'h6;
		end else begin
			reg_index = 4'hF;
		end
	endfunction

	function automatic logic [31:0] wmask(input logic [3:0] idx);
		case (idx)
			4'h0: wmask = LDDR_WMASK_FWD_ENABLES;
			4'h1: wmask = LDDR_WMASK_SLOT9_WINDOW;
			4'h2: wmask = LDDR_WMASK_SERIAL_SLOT10; // [RULE10]
			4'h3, 4'h5: wmask = LDDR_WMASK_IO_WINDOW;
			4'h4, 4'h6: wmask = LDDR_WMASK_MEM_WINDOW;
			default: wmask = 32'h0000_0000;
		endcase
	endfunction

	// Serial port range table, the same for both ports
	function automatic logic ser_match(input logic [2:0] sel, input logic [15:0] a);
		logic [12:0] start;
		start = LDDR_SER_RANGE_0;
		case (sel)
			3'h0: start = LDDR_SER_RANGE_0;
			3'h1: start = LDDR_SER_RANGE_1;
			3'h2: start = LDDR_SER_RANGE_2;
			3'h3: start = LDDR_SER_RANGE_3;
			3'h4: start = LDDR_SER_RANGE_4;
			3'h5: start = LDDR_SER_RANGE_5;
			3'h6: start = LDDR_SER_RANGE_6;
			default: start = LDDR_SER_RANGE_7;
		endcase
		ser_match = (a[15:3] == start); // [RULE4] [RULE6]
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Window comparators

	logic [3:0][31:0] io_reg;
	logic [3:0] io_mon;
	logic [3:0] io_match;
	logic [1:0][31:0] mem_reg;
	logic [1:0] mem_match;

	// Slot 9, slot 10, slot 12 and slot 13 I/O windows share one base and mask layout
	assign io_reg[0] = state_ff.regs[1];
	assign io_reg[1] = state_ff.regs[2];
	assign io_reg[2] = state_ff.regs[3];
	assign io_reg[3] = state_ff.regs[5];
	assign io_mon[0] = state_ff.regs[1][LDDR_BIT_GEN_MON]; // [RULE20]
	assign io_mon[1] = state_ff.regs[2][LDDR_BIT_GEN_MON]; // [RULE9]
	assign io_mon[2] = state_ff.regs[3][LDDR_BIT_IO_MON]; // [RULE11]
	assign io_mon[3] = state_ff.regs[5][LDDR_BIT_IO_MON]; // [RULE16]
	assign mem_reg[0] = state_ff.regs[4];
	assign mem_reg[1] = state_ff.regs[6];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_io
			// Base on address 15:0, mask on address 3:0
			lddr_window_match #(
				.BASE_W(LDDR_IO_BASE_W),
				.MASK_W(LDDR_IO_MASK_W)
			) u_io (
				.addr(cyc_addr[15:0]),
				.base(io_reg[gi][LDDR_POS_IO_BASE +: LDDR_IO_BASE_W]),
				.mask(io_reg[gi][LDDR_POS_IO_MASK +: LDDR_IO_MASK_W]),
				.enable(io_mon[gi] && cyc_valid && cyc_is_io),
				.hit(io_match[gi])
			); // [RULE1] [RULE2] [RULE10] [RULE12] [RULE17]
		end
		for (gi = 0; gi < 2; gi++) begin : g_mem
			// Base on address 31:15, mask low bits land on address 21:15
			lddr_window_match #(
				.BASE_W(LDDR_MEM_BASE_W),
				.MASK_W(LDDR_MEM_MASK_W)
			) u_mem (
				.addr(cyc_addr[31:15]),
				.base(mem_reg[gi][LDDR_POS_MEM_BASE +: LDDR_MEM_BASE_W]),
				.mask(mem_reg[gi][LDDR_POS_MEM_MASK +: LDDR_MEM_MASK_W]),
				.enable(mem_reg[gi][LDDR_BIT_MEM_MON] && cyc_valid && !cyc_is_io),
				.hit(mem_match[gi])
			); // [RULE13] [RULE14] [RULE15] [RULE18] [RULE19]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [31:0] sc_reg;
	logic [31:0] fw_reg;
	logic ser_a_hit;
	logic ser_b_hit;

	assign sc_reg = state_ff.regs[2];
	assign fw_reg = state_ff.regs[0];
	assign ser_a_hit = cyc_valid && cyc_is_io && serial_a_monitor_enable
		&& ser_match(sc_reg[LDDR_POS_SERA_SEL +: LDDR_SEL_W], cyc_addr[15:0]);
	assign ser_b_hit = cyc_valid && cyc_is_io && serial_b_monitor_enable
		&& ser_match(sc_reg[LDDR_POS_SERB_SEL +: LDDR_SEL_W], cyc_addr[15:0]);

	always_comb begin
		logic [3:0] widx;
		logic [3:0] ridx;
		logic [31:0] bmask;
		logic [31:0] wm;
		widx = reg_index(cfg_addr);
		ridx = reg_index(cfg_addr);
		bmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
		wm = wmask(widx) & bmask;
		nxt_state = state_ff;

		// Byte-enabled writes; unmapped offsets are dropped
		if (cfg_wr && widx != 4'hF) begin
			nxt_state.regs[widx] = (state_ff.regs[widx] & ~wm) | (cfg_wdata & wm);
		end

		// Read answer one cycle later; unmapped reads give zero
		nxt_state.rvalid = cfg_rd;
		if (cfg_rd && ridx != 4'hF) begin
			nxt_state.rdata = state_ff.regs[ridx];
		end else begin
			nxt_state.rdata = 32'h0000_0000;
		end

		nxt_state.hit[LDDR_HIT_SLOT9] = io_match[0]; // [RULE23]
		nxt_state.hit[LDDR_HIT_SERA] = ser_a_hit;
		nxt_state.hit[LDDR_HIT_SERB] = ser_b_hit;
		nxt_state.hit[LDDR_HIT_SLOT10] = io_match[1];
		nxt_state.hit[LDDR_HIT_SLOT12_IO] = io_match[2];
		nxt_state.hit[LDDR_HIT_SLOT12_MEM] = mem_match[0];
		nxt_state.hit[LDDR_HIT_SLOT13_IO] = io_match[3];
		nxt_state.hit[LDDR_HIT_SLOT13_MEM] = mem_match[1];

		// Claim for forwarding when the matching forward bit is set
		nxt_state.claim = (io_match[0] && state_ff.regs[1][LDDR_BIT_GEN_FWD])
			|| (ser_b_hit && sc_reg[LDDR_BIT_SERB_FWD]) // [RULE3]
			|| (ser_a_hit && sc_reg[LDDR_BIT_SERA_FWD]) // [RULE5]
			|| (io_match[1] && sc_reg[LDDR_BIT_GEN_FWD]) // [RULE8]
			|| ((io_match[2] || mem_match[0]) && fw_reg[LDDR_BIT_SLOT12_FWD]) // [RULE22]
			|| ((io_match[3] || mem_match[1]) && fw_reg[LDDR_BIT_SLOT13_FWD]); // [RULE22]

		// Chip selects need both the select enable and the forward bit
		nxt_state.sel0_n = !(io_match[0] && state_ff.regs[1][LDDR_BIT_CS_EN]
			&& state_ff.regs[1][LDDR_BIT_GEN_FWD]); // [RULE21]
		nxt_state.sel1_n = !(io_match[1] && sc_reg[LDDR_BIT_CS_EN]
			&& sc_reg[LDDR_BIT_GEN_FWD]); // [RULE7]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// Everything cleared: slot windows stay off until programmed; serial ranges decode on code 0 when their external monitor enables are set
			state_ff.regs <= {LDDR_NUM_REGS{LDDR_REG_RESET}}; // [RULE24]
			state_ff.rdata <= 32'h0000_0000;
			state_ff.rvalid <= 1'b0;
			state_ff.claim <= 1'b0;
			state_ff.sel0_n <= 1'b1;
			state_ff.sel1_n <= 1'b1;
			state_ff.hit <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign cfg_rdata = state_ff.rdata;
	assign cfg_rvalid = state_ff.rvalid;
	assign claim = state_ff.claim;
	assign peripheral_select_0_n = state_ff.sel0_n;
	assign peripheral_select_1_n = state_ff.sel1_n;
	assign window_hit = state_ff.hit;

endmodule

// ### lddr_decoder_asserts.sv
// Port checker for the legacy device range decoder
`timescale 1ns/1ps
module lddr_decoder_asserts
	import lddr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic cfg_rd,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	// Decode path
	input wire logic cyc_valid,
	input wire logic cyc_is_io,
	input wire logic claim,
	input wire logic peripheral_select_0_n,
	input wire logic peripheral_select_1_n,
	input wire logic [7:0] window_hit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	rd_answer_a: assert property (cfg_rd |=> cfg_rvalid) else $error("read unanswered");
	rd_quiet_a: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0) else $error("stray read data");
	idle_out_a: assert property (!cyc_valid |=> window_hit == 8'h00 && !claim) else $error("decode without cycle");
	io_only_a: assert property (cyc_valid && !cyc_is_io |=> (window_hit & 8'h5F) == 8'h00) else $error("memory hit io");
	mem_only_a: assert property (cyc_valid && cyc_is_io |=> (window_hit & 8'hA0) == 8'h00) else $error("io hit memory");
	claim_cause_a: assert property (claim |-> window_hit != 8'h00) else $error("claim without hit");
	sel0_cause_a: assert property (!peripheral_select_0_n |-> claim && window_hit[LDDR_HIT_SLOT9]) else $error("bad select 0");
	sel1_cause_a: assert property (!peripheral_select_1_n |-> claim && window_hit[LDDR_HIT_SLOT10]) else $error("bad select 1");
	reset_clear_a: assert property ($rose(reset_n) |-> !claim && window_hit == 8'h00 && peripheral_select_0_n && peripheral_select_1_n) else $error("reset left state");
endmodule

bind lddr_decoder lddr_decoder_asserts lddr_decoder_asserts_inst (.clk(clk), .reset_n(reset_n), .cfg_rd(cfg_rd),
	.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cyc_valid(cyc_valid), .cyc_is_io(cyc_is_io), .claim(claim),
	.peripheral_select_0_n(peripheral_select_0_n), .peripheral_select_1_n(peripheral_select_1_n), .window_hit(window_hit));

// ### lddr_initiator.sv
// Bus initiator model presenting observed cycles
`timescale 1ns/1ps
module lddr_initiator (
	// Clock
	input wire logic clk,
	// Cycle toward the decoder
	output logic cyc_valid,
	output logic cyc_is_io,
	output logic [31:0] cyc_addr
);
	initial begin
		cyc_valid = 1'b0;
		cyc_is_io = 1'b0;
		cyc_addr = 32'h0;
	end
	// Lines inverted after the cycle so stale values never decode cleanly
	task automatic issue(input logic io, input logic [31:0] a);
		@(negedge clk);
		cyc_valid <= 1'b1;
		cyc_is_io <= io;
		cyc_addr <= a;
		@(negedge clk);
		cyc_valid <= 1'b0;
		cyc_is_io <= ~io;
		cyc_addr <= ~a;
	endtask
endmodule

// ### lddr_decoder_bench.sv
// Self-checking bench for the legacy device range decoder
`timescale 1ns/1ps
module lddr_decoder_bench;
	import lddr_pkg::*;
	logic clk, reset_n, cfg_wr, cfg_rd, cfg_rvalid, cyc_valid, cyc_is_io, claim;
	logic serial_a_monitor_enable, serial_b_monitor_enable, peripheral_select_0_n, peripheral_select_1_n;
	logic [7:0] cfg_addr, window_hit;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, cyc_addr;
	int err_total = 0;
	int checks = 0;
	lddr_decoder lddr_decoder_inst (.clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
		.cfg_rvalid, .serial_a_monitor_enable, .serial_b_monitor_enable, .cyc_valid, .cyc_is_io, .cyc_addr,
		.claim, .peripheral_select_0_n, .peripheral_select_1_n, .window_hit);
	lddr_initiator lddr_initiator_inst (.clk, .cyc_valid, .cyc_is_io, .cyc_addr);
	////////////////////////////////////////
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk({cfg_rvalid, cfg_rdata}, {1'b1, e});
	endtask
	// Expect packs claim, select 0, select 1, then the hit vector
	task automatic cyc(input logic io, input logic [31:0] a, input logic [10:0] e);
		lddr_initiator_inst.issue(io, a);
		chk({22'h0, claim, peripheral_select_0_n, peripheral_select_1_n, window_hit}, {22'h0, e});
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 7; i++) begin
			rd(8'h5C + 8'(4 * i), 32'h0);
		end
		rd(8'h50, 32'h0);
	endtask
	task automatic t_access;
		logic [31:0] m[7] = '{32'h6000_0000, 32'h00EF_FFFF, 32'hFFEF_FFFF, 32'h001F_FFFF, 32'hFFFF_80FF,
			32'h001F_FFFF, 32'hFFFF_80FF};
		for (int i = 0; i < 7; i++) begin
			wr(8'h5C + 8'(4 * i), 32'hFFFF_FFFF);
			rd(8'h5C + 8'(4 * i), m[i]);
			wr(8'h5C + 8'(4 * i), 32'h0);
		end
	endtask
	task automatic t_serial;
		logic [15:0] s[8] = '{16'h3F8, 16'h2F8, 16'h220, 16'h228, 16'h238, 16'h2E8, 16'h338, 16'h3E8};
		serial_a_monitor_enable = 1'b1;
		serial_b_monitor_enable = 1'b1;
		for (int k = 0; k < 8; k++) begin
			// Opposite codes on the two ports so a swapped select cannot hide
			wr(8'h64, {1'b1, 3'(k), 1'b1, 3'(7 - k), 24'h0});
			cyc(1'b1, {16'h0, s[k] + 16'h7}, 11'h704);
			cyc(1'b1, {16'h0, s[7 - k]}, 11'h702);
			cyc(1'b1, {16'h0, s[k] - 16'h1}, 11'h300);
		end
		cyc(1'b0, 32'h3E8, 11'h300);
		serial_a_monitor_enable = 1'b0;
		cyc(1'b1, 32'h3E8, 11'h704);
		wr(8'h64, 32'h7700_0000);
		cyc(1'b1, 32'h3E8, 11'h304);
	endtask
	task automatic t_slot10;
		wr(8'h64, 32'h00E9_0300);
		cyc(1'b1, 32'h0309, 11'h608);
		cyc(1'b1, 32'h0302, 11'h300);
		wr(8'h64, 32'h00C9_0300);
		cyc(1'b1, 32'h0300, 11'h300);
		wr(8'h64, 32'h0069_0300);
		cyc(1'b1, 32'h0300, 11'h708);
		wr(8'h64, 32'h00A9_0300);
		cyc(1'b1, 32'h0300, 11'h308);
		wr(8'h64, 32'h0);
	endtask
	task automatic t_slot9;
		wr(8'h60, 32'h00E0_1234);
		cyc(1'b1, 32'h1234, 11'h501);
		cyc(1'b1, 32'h1235, 11'h300);
		wr(8'h60, 32'h00E8_1234);
		cyc(1'b1, 32'h123C, 11'h501);
		wr(8'h60, 32'h0020_1234);
		cyc(1'b1, 32'h1234, 11'h301);
	endtask
	task automatic t_slot1213;
		logic [7:0] o;
		for (int s = 0; s < 2; s++) begin
			o = 8'h68 + 8'(8 * s);
			wr(o, 32'h001F_0400);
			cyc(1'b1, 32'h040F, {3'b011, 8'(8'h10 << (2 * s))});
			wr(o + 8'h4, 32'h0040_00F3);
			cyc(1'b0, 32'h0068_0000, {3'b011, 8'(8'h20 << (2 * s))});
			cyc(1'b0, 32'h0044_0000, 11'h300);
			cyc(1'b0, 32'h0028_0000, 11'h300);
			wr(8'h5C, 32'h2000_0000 << s);
			cyc(1'b1, 32'h0400, {3'b111, 8'(8'h10 << (2 * s))});
			wr(o + 8'h4, 32'h0040_0073);
			cyc(1'b0, 32'h0040_0000, 11'h300);
			wr(o, 32'h000F_0400);
			cyc(1'b1, 32'h0400, 11'h300);
			wr(8'h5C, 32'h0);
		end
	endtask
	// Partial byte lanes and unmapped writes must leave other bits alone
	task automatic t_bytes;
		cfg_be = 4'h5;
		wr(8'h70, 32'hFFFF_FFFF);
		cfg_be = 4'hF;
		rd(8'h70, 32'h001F_04FF);
		wr(8'h78, 32'hFFFF_FFFF);
		rd(8'h74, 32'h0040_0073);
		wr(8'h70, 32'h0);
	endtask
	// Mid-run reset must drop a programmed window
	task automatic t_rereset;
		wr(8'h60, 32'h00E0_1234);
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		rd(8'h60, 32'h0);
		cyc(1'b1, 32'h1234, 11'h300);
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{reset_n, cfg_wr, cfg_rd, serial_a_monitor_enable, serial_b_monitor_enable} = 5'h0;
		cfg_addr = 8'h0;
		cfg_be = 4'hF;
		cfg_wdata = 32'h0;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_access();
		t_serial();
		t_slot10();
		t_slot9();
		t_slot1213();
		t_bytes();
		t_rereset();
		results();
	end
	// Run needs well under a thousand cycles
	initial begin
		#100us;
		err_total++;
		results();
	end
endmodule
